// file: verilog/gsm_consts.svh
// Overview of operation
// - Host writes that land in the virtual region (0x80 up to 0xC0 and above) are ignored.
// - Status bit 6 shows that the crystal failed and the core runs on the ring oscillator.
// - After a crystal failure the serial port is flagged slow and energy flagged inaccurate.
// - Status bit 5 is set by a power-on reset and cleared by a host write of zero.
// - Status bit 4 is set by a watchdog reset and cleared by a host write of zero.
// - Status bit 2 reads 0 for forward phase order and 1 for reversed order.
// - Status bit 1 reads 1 when the second pulse output carries a negative quantity.
// - Status bit 0 reads 1 when the first pulse output carries a negative quantity.
// - Mode bit 4 disables the crystal and turns the crystal pin into a clock input.
// - Mode bit 3 restarts the firmware from its reset vector without touching peripherals.
// - Mode bit 3 clears itself once the restart has taken place.
// - Mode bit 2 suspends signal processing while the processor keeps running.
// - Mode bit 1 moves the processor clock to the nominal 1MHz ring oscillator.
`ifndef GSM_CONSTS_SVH
`define GSM_CONSTS_SVH

// ****************************************
// register offsets
// ****************************************
`define GSM_OFS_STATUS     12'h000
`define GSM_OFS_MODE0      12'h001
`define GSM_VIRT_BASE      12'h080
`define GSM_VIRT_SFR       12'h0C0

// ****************************************
// status fields
// ****************************************
`define GSM_ST_XTAL_FAIL   6
`define GSM_ST_POR         5
`define GSM_ST_WDT         4
`define GSM_ST_PHASE_SEQUENCE_REVERSED       2
`define GSM_ST_REV2        1
`define GSM_ST_REV1        0
`define GSM_ST_MASK        8'h77

// ****************************************
// mode fields
// ****************************************
`define GSM_MD_EXTERNAL_CLOCK_SELECT      4
`define GSM_MD_RESTART     3
`define GSM_MD_DSPOFF      2
`define GSM_MD_LOW_POWER_CLOCK_MODE       1
`define GSM_MD_MASK        8'h1E
`define GSM_RESET_VAL      8'h00

`endif

// file: verilog/gsm_pkg.sv
package gsm_pkg;
   typedef enum logic [2:0] {
      GSM_RS_IDLE = 3'b001,
      GSM_RS_PEND = 3'b010,
      GSM_RS_DONE = 3'b100
   } gsm_rst_state_t;
endpackage

// file: verilog/gsm_sync2.sv
`timescale 1ns/1ps
// ****************************************
// two-flop synchroniser for a bus of levels
// ****************************************
module gsm_sync2 #(
   parameter int W = 1
) (
   input  wire logic         clk,    // core clock
   input  wire logic         rst_n,  // async reset, low
   input  wire logic [W-1:0] d,      // asynchronous levels
   output logic      [W-1:0] q       // synchronised levels
);
   logic [W-1:0] meta;

   // first flop read only by second
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta <= '0;
         q    <= '0;
      end else begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule

// file: verilog/gsm_regs.sv
`timescale 1ns/1ps
`include "gsm_consts.svh"
// ****************************************
// global status and operating mode registers
// ****************************************
module gsm_regs
   import gsm_pkg::*;
(
   input  wire logic        CLK,                  // core clock, 100 MHz
   input  wire logic        RESET_N,              // power-on reset, low
   input  wire logic [11:0] ADDR,                 // register address
   input  wire logic        WR_EN,                // write strobe, one cycle
   input  wire logic [7:0]  WR_DATA,              // write data
   input  wire logic        RD_EN,                // read strobe, one cycle
   output logic      [7:0]  RD_DATA,              // read data, next cycle
   output logic             RD_VALID,             // read data valid pulse
   input  wire logic        WATCHDOG_RESET,       // pulse: watchdog reset occurred
   input  wire logic        RESTART_DONE,         // pulse: firmware restart done
   input  wire logic        XTAL_FAIL_IN,         // async: crystal stopped
   input  wire logic        PHASE_REV_IN,         // async: phase order reversed
   input  wire logic        PULSE1_NEG_IN,        // async: first pulse negative
   input  wire logic        PULSE2_NEG_IN,        // async: second pulse negative
   output logic             EXTERNAL_CLOCK_SELECT,// crystal off, pin is clock in
   output logic             SOFTWARE_RESTART,     // firmware restart request
   output logic             SIGNAL_PROCESSING_DISABLE, // dsp routines suspended
   output logic             LOW_POWER_CLOCK_MODE, // cpu on ring oscillator
   output logic             RING_OSC_ACTIVE,      // core runs on ring oscillator
   output logic             SERIAL_SLOW,          // serial port below full speed
   output logic             ENERGY_INACCURATE     // energy accumulation flagged
);
   logic [3:0]     sync_q;
   logic           crystal_failed_flag;
   logic           power_on_reset_flag;
   logic           watchdog_reset_flag;
   logic           phase_sequence_reversed;
   logic           second_pulse_reverse_flag;
   logic           first_pulse_reverse_flag;
   logic [7:0]     operating_mode_zero;
   logic [7:0]     global_status;
   logic           por_seen;
   gsm_rst_state_t rs_state;
   gsm_rst_state_t next_rs_state;
   logic           wr_status;
   logic           wr_mode;
   logic           restart_req;
   logic           restart_clr;

   // ****************************************
   // address decode
   // ****************************************
   function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
      hit = (a == ofs);
   endfunction

   // virtual region never decodes, so writes there fall away
   assign wr_status = WR_EN && hit(ADDR, `GSM_OFS_STATUS);
   assign wr_mode   = WR_EN && hit(ADDR, `GSM_OFS_MODE0);

   // host request and firmware acknowledge for the restart bit
   assign restart_req = wr_mode && WR_DATA[`GSM_MD_RESTART];
   assign restart_clr = (rs_state == GSM_RS_PEND) && RESTART_DONE && !restart_req;

   // ****************************************
   // pin synchronisers
   // ****************************************
   gsm_sync2 #(.W(4)) u_sync (
      .clk   (CLK),
      .rst_n (RESET_N),
      .d     ({XTAL_FAIL_IN, PHASE_REV_IN, PULSE2_NEG_IN, PULSE1_NEG_IN}),
      .q     (sync_q)
   );

   // live status bits follow synchronised inputs
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         crystal_failed_flag       <= 1'b0;
         phase_sequence_reversed   <= 1'b0;
         second_pulse_reverse_flag <= 1'b0;
         first_pulse_reverse_flag  <= 1'b0;
      end else begin
         crystal_failed_flag       <= sync_q[3];
         phase_sequence_reversed   <= sync_q[2];
         second_pulse_reverse_flag <= sync_q[1];
         first_pulse_reverse_flag  <= sync_q[0];
      end
   end

   // power-on flag: set once after release, set beats host clear
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         por_seen            <= 1'b0;
         power_on_reset_flag <= 1'b0;
      end else begin
         por_seen <= 1'b1;
         if (!por_seen) begin
            power_on_reset_flag <= 1'b1;
         end else if (wr_status) begin
            power_on_reset_flag <= WR_DATA[`GSM_ST_POR];
         end
      end
   end

   // watchdog flag: set wins over host clear
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         watchdog_reset_flag <= 1'b0;
      end else if (WATCHDOG_RESET) begin
         watchdog_reset_flag <= 1'b1;
      end else if (wr_status) begin
         watchdog_reset_flag <= WR_DATA[`GSM_ST_WDT];
      end
   end

   // ****************************************
   // restart sequencer
   // ****************************************
   // a fresh request always re-arms, so a set bit never goes unwatched
   always_comb begin
      next_rs_state = rs_state;
      case (rs_state)
         GSM_RS_IDLE: begin
            if (restart_req) begin
               next_rs_state = GSM_RS_PEND;
            end
         end
         GSM_RS_PEND: begin
            if (restart_req) begin
               next_rs_state = GSM_RS_PEND;
            end else if (RESTART_DONE) begin
               next_rs_state = GSM_RS_DONE;
            end
         end
         GSM_RS_DONE: begin
            if (restart_req) begin
               next_rs_state = GSM_RS_PEND;
            end else begin
               next_rs_state = GSM_RS_IDLE;
            end
         end
         default: begin
            next_rs_state = GSM_RS_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         rs_state <= GSM_RS_IDLE;
      end else begin
         rs_state <= next_rs_state;
      end
   end

   // mode register, reserved bits held at zero
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         operating_mode_zero <= `GSM_RESET_VAL;
      end else begin
         if (wr_mode) begin
            operating_mode_zero <= WR_DATA & `GSM_MD_MASK;
         end
         if (restart_clr) begin
            operating_mode_zero[`GSM_MD_RESTART] <= 1'b0;
         end
      end
   end

   // ****************************************
   // mode and clock outputs
   // ****************************************
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         EXTERNAL_CLOCK_SELECT     <= 1'b0;
         SOFTWARE_RESTART          <= 1'b0;
         SIGNAL_PROCESSING_DISABLE <= 1'b0;
         LOW_POWER_CLOCK_MODE      <= 1'b0;
         RING_OSC_ACTIVE           <= 1'b0;
         SERIAL_SLOW               <= 1'b0;
         ENERGY_INACCURATE         <= 1'b0;
      end else begin
         EXTERNAL_CLOCK_SELECT     <= operating_mode_zero[`GSM_MD_EXTERNAL_CLOCK_SELECT];
         SOFTWARE_RESTART          <= operating_mode_zero[`GSM_MD_RESTART];
         SIGNAL_PROCESSING_DISABLE <= operating_mode_zero[`GSM_MD_DSPOFF];
         LOW_POWER_CLOCK_MODE      <= operating_mode_zero[`GSM_MD_LOW_POWER_CLOCK_MODE];
         RING_OSC_ACTIVE           <= operating_mode_zero[`GSM_MD_LOW_POWER_CLOCK_MODE] |
                                      crystal_failed_flag;
         SERIAL_SLOW               <= crystal_failed_flag;
         ENERGY_INACCURATE         <= crystal_failed_flag;
      end
   end

   // status assembly, reserved bits zero
   always_comb begin
      global_status = 8'h00;
      global_status[`GSM_ST_XTAL_FAIL] = crystal_failed_flag;
      global_status[`GSM_ST_POR]       = power_on_reset_flag;
      global_status[`GSM_ST_WDT]       = watchdog_reset_flag;
      global_status[`GSM_ST_PHASE_SEQUENCE_REVERSED]     = phase_sequence_reversed;
      global_status[`GSM_ST_REV2]      = second_pulse_reverse_flag;
      global_status[`GSM_ST_REV1]      = first_pulse_reverse_flag;
   end

   // ****************************************
   // read port
   // ****************************************
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         RD_DATA  <= 8'h00;
         RD_VALID <= 1'b0;
      end else begin
         RD_VALID <= RD_EN;
         if (RD_EN) begin
            if (hit(ADDR, `GSM_OFS_STATUS)) begin
               RD_DATA <= global_status & `GSM_ST_MASK;
            end else if (hit(ADDR, `GSM_OFS_MODE0)) begin
               RD_DATA <= operating_mode_zero;
            end else begin
               RD_DATA <= 8'h00;
            end
         end
      end
   end
endmodule

// file: verif/gsm_host_model.sv
`timescale 1ns/1ps
// ****
// host master model driving register strobes
// ****
module gsm_host_model (
   input  wire logic        clk,     // core clock
   output logic      [11:0] addr,    // address
   output logic             wr_en,   // write strobe
   output logic      [7:0]  wr_data, // write data
   output logic             rd_en    // read strobe
);
   // idle bus at time zero
   initial begin
      addr = 12'h000;
      wr_en = 1'b0;
      wr_data = 8'h00;
      rd_en = 1'b0;
   end
   // one write, held over one edge; flag clears and reconfig
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge clk);
      #1;
      addr = a;
      wr_data = d;
      wr_en = 1'b1;
      @(posedge clk);
      #1;
      wr_en = 1'b0;
      addr = ~a;
      wr_data = ~d;
   endtask
   // one read strobe; released address shows its inverse
   task automatic rd(input logic [11:0] a);
      @(posedge clk);
      #1;
      addr = a;
      rd_en = 1'b1;
      @(posedge clk);
      #1;
      rd_en = 1'b0;
      addr = ~a;
   endtask
endmodule

// file: verif/gsm_regs_chk.sv
`timescale 1ns/1ps
// ****
// port checker
// ****
module gsm_regs_chk (
   input wire logic        CLK,                       // clock
   input wire logic        RESET_N,                   // reset
   input wire logic [11:0] ADDR,                      // address
   input wire logic        WR_EN,                     // write
   input wire logic [7:0]  WR_DATA,                   // wdata
   input wire logic        RD_EN,                     // read
   input wire logic [7:0]  RD_DATA,                   // rdata
   input wire logic        RESTART_DONE,              // done
   input wire logic        XTAL_FAIL_IN,              // xtal
   input wire logic        EXTERNAL_CLOCK_SELECT,     // ext
   input wire logic        SOFTWARE_RESTART,          // restart
   input wire logic        SIGNAL_PROCESSING_DISABLE, // dsp
   input wire logic        LOW_POWER_CLOCK_MODE,      // low_power_clock_mode
   input wire logic        RING_OSC_ACTIVE,           // ring
   input wire logic        SERIAL_SLOW,               // slow
   input wire logic        ENERGY_INACCURATE          // energy
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RESET_N);
   // read data contents
   property p_unmapped; RD_EN && ADDR > 12'h001 |=> RD_DATA == 8'h00; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_st_resv; RD_EN && ADDR == 12'h000 |=> !RD_DATA[7] && !RD_DATA[3]; endproperty
   a_st_resv: assert property (p_st_resv) else $error("status reserved set");
   property p_md_resv; RD_EN && ADDR == 12'h001 |=> (RD_DATA & 8'hE1) == 8'h00; endproperty
   a_md_resv: assert property (p_md_resv) else $error("mode reserved set");
   // mode outputs follow writes two cycles on
   property p_mode_out;
      WR_EN && ADDR == 12'h001 ##1 !(WR_EN && ADDR == 12'h001) |=>
         {3'h0, EXTERNAL_CLOCK_SELECT, 1'b0, SIGNAL_PROCESSING_DISABLE, LOW_POWER_CLOCK_MODE,
          1'b0} == ($past(WR_DATA, 2) & 8'h16);
   endproperty
   a_mode_out: assert property (p_mode_out)
      else $error("mode outputs wrong");
   property p_virt_wr;
      WR_EN && ADDR >= 12'h080 |=> ##1
         $stable({EXTERNAL_CLOCK_SELECT, SIGNAL_PROCESSING_DISABLE, LOW_POWER_CLOCK_MODE});
   endproperty
   a_virt_wr: assert property (p_virt_wr) else $error("virtual write took effect");
   property p_rst_set; WR_EN && ADDR == 12'h001 && WR_DATA[3] |=> ##1 SOFTWARE_RESTART; endproperty
   a_rst_set: assert property (p_rst_set) else $error("restart not raised");
   property p_rst_clr;
      RESTART_DONE && SOFTWARE_RESTART && !WR_EN |=> ##1 !SOFTWARE_RESTART;
   endproperty
   a_rst_clr: assert property (p_rst_clr) else $error("restart not cleared");
   // crystal failure flags
   property p_xtal;
      XTAL_FAIL_IN [*6] |-> SERIAL_SLOW && ENERGY_INACCURATE && RING_OSC_ACTIVE;
   endproperty
   a_xtal: assert property (p_xtal)
      else $error("crystal failure not flagged");
   property p_ring; RING_OSC_ACTIVE == (LOW_POWER_CLOCK_MODE || SERIAL_SLOW); endproperty
   a_ring: assert property (p_ring) else $error("ring oscillator state wrong");
   // main scenarios reached
   c_rst_clr: cover property (RESTART_DONE && SOFTWARE_RESTART);
   c_virt: cover property (WR_EN && ADDR >= 12'h080);
   c_xtal: cover property (XTAL_FAIL_IN [*6]);
endmodule
bind gsm_regs gsm_regs_chk u_chk (
   .CLK(CLK), .RESET_N(RESET_N), .ADDR(ADDR), .WR_EN(WR_EN), .WR_DATA(WR_DATA),
   .RD_EN(RD_EN), .RD_DATA(RD_DATA), .RESTART_DONE(RESTART_DONE),
   .XTAL_FAIL_IN(XTAL_FAIL_IN), .EXTERNAL_CLOCK_SELECT(EXTERNAL_CLOCK_SELECT),
   .SOFTWARE_RESTART(SOFTWARE_RESTART), .SIGNAL_PROCESSING_DISABLE(SIGNAL_PROCESSING_DISABLE),
   .LOW_POWER_CLOCK_MODE(LOW_POWER_CLOCK_MODE), .RING_OSC_ACTIVE(RING_OSC_ACTIVE),
   .SERIAL_SLOW(SERIAL_SLOW), .ENERGY_INACCURATE(ENERGY_INACCURATE)
);

// file: verif/gsm_regs_test.sv
`timescale 1ns/1ps
// ****
// register bank testbench
// ****
module gsm_regs_test;
   logic        clk = 1'b0;
   logic        reset_n = 1'b0;
   logic [11:0] addr;
   logic        wr_en, rd_en, rd_valid, swr, ext, dsp, low_power_clock_mode, ring, slow, energy;
   logic [7:0]  wr_data, rd_data, d;
   logic        wdog = 1'b0, rdone = 1'b0, xtal = 1'b0, phase = 1'b0, p1 = 1'b0, p2 = 1'b0;
   logic [7:0]  exp_q[$];
   int          num_errors = 0, n_compared = 0, cyc = 0;
   always #5 clk = ~clk;
   gsm_host_model host (.clk(clk), .addr(addr), .wr_en(wr_en), .wr_data(wr_data), .rd_en(rd_en));
   gsm_regs dut (.CLK(clk), .RESET_N(reset_n), .ADDR(addr), .WR_EN(wr_en), .WR_DATA(wr_data),
      .RD_EN(rd_en), .RD_DATA(rd_data), .RD_VALID(rd_valid), .WATCHDOG_RESET(wdog),
      .RESTART_DONE(rdone), .XTAL_FAIL_IN(xtal), .PHASE_REV_IN(phase), .PULSE1_NEG_IN(p1),
      .PULSE2_NEG_IN(p2), .EXTERNAL_CLOCK_SELECT(ext), .SOFTWARE_RESTART(swr),
      .SIGNAL_PROCESSING_DISABLE(dsp), .LOW_POWER_CLOCK_MODE(low_power_clock_mode), .RING_OSC_ACTIVE(ring),
      .SERIAL_SLOW(slow), .ENERGY_INACCURATE(energy));
   // compare and count
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic rd(input logic [11:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      host.rd(a);
   endtask
   task automatic hold(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic report_and_stop;
      num_errors += exp_q.size();
      $display("compared %0d errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // read results against oldest note
   always @(negedge clk) begin
      if (rd_valid === 1'b1) begin
         if (exp_q.size() > 0)
            cmp(rd_data, exp_q.pop_front());
         else begin
            num_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, rd_data, 8'h00);
         end
      end
   end
   // hang guard
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         num_errors++;
         report_and_stop();
      end
   end
   // main sequence
   initial begin
      void'($urandom(32'h2d7a7170));
      hold(8);
      reset_n = 1'b1;
      rd(12'h000, 8'h20);
      rd(12'h001, 8'h00);
      host.wr(12'h000, 8'hCF);
      rd(12'h000, 8'h00);
      wdog = 1'b1;
      hold(1);
      wdog = 1'b0;
      rd(12'h000, 8'h10);
      host.wr(12'h000, 8'h00);
      rd(12'h000, 8'h00);
      $display("test flags done");
      for (int i = 0; i < 8; i++) begin
         {xtal, phase, p2, p1} = 4'($urandom);
         hold(4);
         cmp({5'h00, ring, slow, energy}, {5'h00, xtal, xtal, xtal});
         d = {1'b0, xtal, 3'b000, phase, p2, p1};
         rd(12'h000, d);
      end
      {xtal, phase, p2, p1} = 4'h0;
      hold(4);
      $display("test inputs done");
      for (int i = 0; i < 8; i++) begin
         d = 8'($urandom) & 8'hF7;
         host.wr(12'h001, d);
         hold(2);
         cmp({3'h0, ext, 1'b0, dsp, low_power_clock_mode, 1'b0}, d & 8'h16);
         rd(12'h001, d & 8'h16);
      end
      $display("test mode done");
      host.wr(12'h001, 8'h08);
      hold(2);
      cmp({7'h00, swr}, 8'h01);
      rd(12'h001, 8'h08);
      rdone = 1'b1;
      hold(1);
      rdone = 1'b0;
      hold(2);
      cmp({7'h00, swr}, 8'h00);
      rd(12'h001, 8'h00);
      $display("test restart done");
      host.wr(12'h001, 8'h16);
      host.wr(12'h081, 8'h00);
      host.wr(12'h0C1, 8'h00);
      hold(2);
      cmp({7'h00, ring}, 8'h01);
      rd(12'h001, 8'h16);
      rd(12'h0C0, 8'h00);
      hold(3);
      $display("test virtual done");
      reset_n = 1'b0;
      hold(2);
      cmp({4'h0, ext, swr, dsp, low_power_clock_mode}, 8'h00);
      reset_n = 1'b1;
      rd(12'h001, 8'h00);
      rd(12'h000, 8'h20);
      hold(3);
      $display("test reset done");
      report_and_stop();
   end
endmodule
